//--- rtl/gpsbb_pkg.sv
package gpsbb_pkg;
  // register offsets (byte addresses in I/O space)
  localparam logic [7:0]  OFF_CTRL_STAT = 8'h00;
  localparam logic [7:0]  OFF_IRQ_CTRL  = 8'h02;
  localparam logic [7:0]  OFF_UART_DATA = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h06;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  OFF_IDENT     = 8'hFE;
  // interrupt control field positions, then the pulse bit of control/status
  localparam int BIT_UIEN = 0;
  localparam int BIT_PIEN = 1;
  localparam int BIT_MASTER_IRQ_ENABLE = 3;
  localparam int BIT_URTI = 4;
  localparam int BIT_PPS_CHANGE_PENDING = 5;
  localparam int BIT_IT   = 7;
  localparam int BIT_PPS  = 1;
  // status event bits
  localparam int EV_PPS_CHG = 0;
  localparam int EV_RX_DATA = 1;
  localparam int EV_RX_OVF  = 2;
  localparam logic [15:0] FIFO_EMPTY_WORD = 16'h00FF;
  localparam logic [15:0] IDENT_RESET     = 16'h0000;
  localparam logic [2:0]  EV_MASK_RESET   = 3'h0;
  // timing
  localparam longint CLK_HZ        = 25000000;
  localparam longint PPS_TMO_MS    = 1300;
  localparam int     PPS_TMO_CYC   = int'((PPS_TMO_MS * CLK_HZ) / 1000);
  localparam int     BAUD          = 9600;
  localparam logic [11:0] BIT_CYC  = 12'(CLK_HZ / BAUD);
  localparam int     FIFO_DEPTH    = 512;
  localparam int     FIFO_AW       = 9;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gpsbb_bus_type;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} gpsbb_tx_type;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} gpsbb_rx_type;
endpackage

//--- rtl/gpsbb_fifo_mem.sv
`timescale 1ns/1ps
// byte memory for the receive queue, registered read port
module gpsbb_fifo_mem (
  input  wire logic                        sys_clk_in,
  input  wire logic                        we_in,
  input  wire logic [gpsbb_pkg::FIFO_AW-1:0] waddr_in,
  input  wire logic [7:0]                  wdata_in,
  input  wire logic [gpsbb_pkg::FIFO_AW-1:0] raddr_in,
  output logic      [7:0]                  rdata_out
);
  logic [7:0] mem [gpsbb_pkg::FIFO_DEPTH];

  // no reset: contents are only meaningful once written
  always_ff @(posedge sys_clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule

//--- rtl/gpsbb_top.sv
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module gpsbb_top (
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        iospace_in,
  input  wire logic        iack_in,
  input  wire logic        pps_in,
  input  wire logic        rx_in,
  input  wire logic [15:0] ident_in,
  output logic      [15:0] rdata_out,
  output logic      [7:0]  vector_out,
  output logic             vector_valid_out,
  output logic             irq_out,
  output logic             tx_out,
  output logic             pps_active_flag_out,
  output logic             pps_lamp_out,
  output logic             ident_sel_out,
  output logic      [15:0] ident_wdata_out
);
  typedef struct packed {
    // pulse watch and activity, interrupt control, read data, vector and ident
    logic [1:0]  pps_sync;
    logic        pps_prev;
    logic [26:0] wdog;
    logic        act;
    logic        uien;
    logic        pien;
    logic        master_irq_enable;
    logic        it;
    logic        pps_change_pending;
    logic        urti;
    logic [2:0]  ev_stat;
    logic [2:0]  ev_mask;
    logic [15:0] rdata;
    logic [7:0]  vector;
    logic        vec_vld;
    logic [15:0] ident;
    // serial transmit
    gpsbb_pkg::gpsbb_tx_type tx_st;
    logic [11:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    logic [7:0]  tx_pend;
    logic        tx_full;
    // serial receive and queue pointers
    gpsbb_pkg::gpsbb_rx_type rx_st;
    logic [1:0]  rx_sync;
    logic [11:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic [gpsbb_pkg::FIFO_AW:0] wp;
    logic [gpsbb_pkg::FIFO_AW:0] rp;
    logic        pop_pend;
  } gpsbb_state_type;

  gpsbb_state_type         s_q, s_d;
  gpsbb_pkg::gpsbb_bus_type bus;
  logic                    fifo_we;
  logic [7:0]              fifo_rdata;
  logic [7:0]              fifo_wbyte;

  // byte count in the queue
  function automatic logic [gpsbb_pkg::FIFO_AW:0] fill_of(
      input logic [gpsbb_pkg::FIFO_AW:0] wp, input logic [gpsbb_pkg::FIFO_AW:0] rp);
    fill_of = wp - rp;
  endfunction

  // I/O space address match
  function automatic logic hit(input logic io, input logic [7:0] a, input logic [7:0] off);
    hit = io && (a == off);
  endfunction

  // write strobe aimed at one register; strobes outside I/O space never land
  function automatic logic wr_hit(input gpsbb_pkg::gpsbb_bus_type b, input logic io,
      input logic [7:0] off);
    wr_hit = b.wr && hit(io, b.addr, off);
  endfunction

  // pointers carry one extra bit so that full and empty differ
  function automatic logic [gpsbb_pkg::FIFO_AW:0] ptr_inc(
      input logic [gpsbb_pkg::FIFO_AW:0] p);
    ptr_inc = p + 10'h1;
  endfunction

  // last count of one bit time, shared by both serial directions
  function automatic logic [11:0] bit_last();
    bit_last = gpsbb_pkg::BIT_CYC - 12'h1;
  endfunction

  // low byte of interrupt control; read back and handed out as the vector
  function automatic logic [7:0] icr_byte(input gpsbb_state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[gpsbb_pkg::BIT_UIEN] = s.uien;
    v[gpsbb_pkg::BIT_PIEN] = s.pien;
    v[gpsbb_pkg::BIT_MASTER_IRQ_ENABLE] = s.master_irq_enable;
    v[gpsbb_pkg::BIT_URTI] = s.urti;
    v[gpsbb_pkg::BIT_PPS_CHANGE_PENDING] = s.pps_change_pending;
    v[gpsbb_pkg::BIT_IT]   = s.it;
    return v;
  endfunction

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  gpsbb_fifo_mem u_mem (
    .sys_clk_in (sys_clk_in),
    .we_in      (fifo_we),
    .waddr_in   (s_q.wp[gpsbb_pkg::FIFO_AW-1:0]),
    .wdata_in   (fifo_wbyte),
    .raddr_in   (s_q.rp[gpsbb_pkg::FIFO_AW-1:0]),
    .rdata_out  (fifo_rdata)
  );

  // next-state logic for the whole block
  always_comb begin
    // per-cycle helper terms
    logic pps_rise;
    logic act_n;
    logic act_chg;
    logic fifo_empty;
    logic fifo_full;
    logic rx_done;
    logic [2:0] ev_set;
    // every field holds unless a line below moves it; pop_pend, rdata and vec_vld return to zero each cycle
    s_d = s_q;
    pps_rise = 1'b0;
    act_n = s_q.act;
    act_chg = 1'b0;
    fifo_empty = 1'b0;
    fifo_full = 1'b0;
    rx_done = 1'b0;
    ev_set = 3'h0;
    fifo_we = 1'b0;
    fifo_wbyte = s_q.rx_sh;

    // pulse watch: two-stage sync, then edge
    s_d.pps_sync = {s_q.pps_sync[0], pps_in};
    s_d.pps_prev = s_q.pps_sync[1];
    pps_rise = s_q.pps_sync[1] && !s_q.pps_prev;
    // watchdog restarted by each pulse
    if (pps_rise) begin
      s_d.wdog = 27'(gpsbb_pkg::PPS_TMO_CYC);
      act_n = 1'b1;
    end else if (s_q.wdog != 27'h0) begin
      s_d.wdog = s_q.wdog - 27'h1;
      if (s_q.wdog == 27'h1) begin
        act_n = 1'b0;
      end
    end
    s_d.act = act_n;
    act_chg = act_n != s_q.act;

    // serial receive, 8N1, mid-bit sampling
    s_d.rx_sync = {s_q.rx_sync[0], rx_in};
    unique case (s_q.rx_st)
      // a low level on the resting line is taken as a start bit
      gpsbb_pkg::RX_IDLE: begin
        if (!s_q.rx_sync[1]) begin
          s_d.rx_st = gpsbb_pkg::RX_SHIFT;
          s_d.rx_cnt = {1'b0, gpsbb_pkg::BIT_CYC[11:1]};
          s_d.rx_bit = 4'h0;
        end
      end
      // half a bit first, so every later sample lands mid-bit
      gpsbb_pkg::RX_SHIFT: begin
        if (s_q.rx_cnt != 12'h0) begin
          s_d.rx_cnt = s_q.rx_cnt - 12'h1;
        end else begin
          s_d.rx_cnt = bit_last();
          s_d.rx_bit = s_q.rx_bit + 4'h1;
          if (s_q.rx_bit == 4'h0 && s_q.rx_sync[1]) begin
            s_d.rx_st = gpsbb_pkg::RX_IDLE; // false start
          end else if (s_q.rx_bit == 4'h9) begin
            s_d.rx_st = gpsbb_pkg::RX_IDLE;
            rx_done = s_q.rx_sync[1]; // drop bytes with bad stop bit
          end else if (s_q.rx_bit != 4'h0) begin
            s_d.rx_sh = {s_q.rx_sync[1], s_q.rx_sh[7:1]};
          end
        end
      end
      default: s_d.rx_st = gpsbb_pkg::RX_IDLE;
    endcase

    // queue received bytes; overflow drops the new byte
    fifo_full = fill_of(s_q.wp, s_q.rp) == 10'(gpsbb_pkg::FIFO_DEPTH);
    fifo_empty = s_q.wp == s_q.rp;
    if (rx_done) begin
      if (!fifo_full) begin
        fifo_we = 1'b1;
        s_d.wp = ptr_inc(s_q.wp);
        ev_set[gpsbb_pkg::EV_RX_DATA] = 1'b1;
      end else begin
        ev_set[gpsbb_pkg::EV_RX_OVF] = 1'b1;
      end
    end

    // serial transmit with one pending byte
    unique case (s_q.tx_st)
      // pending byte moves into the shifter framed by start and stop bits
      gpsbb_pkg::TX_IDLE: begin
        if (s_q.tx_full) begin
          s_d.tx_sh = {1'b1, s_q.tx_pend, 1'b0};
          s_d.tx_full = 1'b0;
          s_d.tx_cnt = bit_last();
          s_d.tx_bit = 4'h0;
          s_d.tx_st = gpsbb_pkg::TX_SHIFT;
        end
      end
      // one full bit time per shift; ones fill in behind the stop bit
      gpsbb_pkg::TX_SHIFT: begin
        if (s_q.tx_cnt != 12'h0) begin
          s_d.tx_cnt = s_q.tx_cnt - 12'h1;
        end else begin
          s_d.tx_cnt = bit_last();
          s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
          s_d.tx_bit = s_q.tx_bit + 4'h1;
          if (s_q.tx_bit == 4'h9) begin
            s_d.tx_st = gpsbb_pkg::TX_IDLE;
          end
        end
      end
      default: s_d.tx_st = gpsbb_pkg::TX_IDLE;
    endcase

    // the popped byte appears from memory one cycle after the read
    s_d.pop_pend = 1'b0;
    s_d.rdata = 16'h0000;
    s_d.vec_vld = 1'b0;

    // register writes
    if (wr_hit(bus, iospace_in, gpsbb_pkg::OFF_IRQ_CTRL)) begin
      s_d.uien = bus.wdata[gpsbb_pkg::BIT_UIEN];
      s_d.pien = bus.wdata[gpsbb_pkg::BIT_PIEN];
      s_d.master_irq_enable = bus.wdata[gpsbb_pkg::BIT_MASTER_IRQ_ENABLE];
      s_d.it   = bus.wdata[gpsbb_pkg::BIT_IT];
      if (bus.wdata[gpsbb_pkg::BIT_PPS_CHANGE_PENDING]) begin
        s_d.pps_change_pending = 1'b0;
      end
      if (bus.wdata[gpsbb_pkg::BIT_URTI]) begin
        s_d.urti = 1'b0;
      end
    end
    // only one byte waits; software must pace its writes to the line rate
    if (wr_hit(bus, iospace_in, gpsbb_pkg::OFF_UART_DATA)) begin
      s_d.tx_pend = bus.wdata[7:0]; // a byte written while busy replaces the pending one
      s_d.tx_full = 1'b1;
    end
    // a set mask bit lets its status bit onto the request line
    if (wr_hit(bus, iospace_in, gpsbb_pkg::OFF_IRQ_MASK)) begin
      s_d.ev_mask = bus.wdata[2:0];
    end
    // word drives the serial id memory lines directly
    if (wr_hit(bus, iospace_in, gpsbb_pkg::OFF_IDENT)) begin
      s_d.ident = bus.wdata;
    end

    // register reads, answered in the next cycle
    if (bus.rd && iospace_in) begin
      unique case (bus.addr)
        gpsbb_pkg::OFF_CTRL_STAT: s_d.rdata[gpsbb_pkg::BIT_PPS] = s_q.act;
        gpsbb_pkg::OFF_IRQ_CTRL: s_d.rdata = {8'h00, icr_byte(s_q)};
        gpsbb_pkg::OFF_UART_DATA: begin
          if (fifo_empty) begin
            s_d.rdata = gpsbb_pkg::FIFO_EMPTY_WORD;
          end else begin
            s_d.pop_pend = 1'b1;
            s_d.rp = ptr_inc(s_q.rp);
          end
        end
        // an event in the same cycle is not lost: it is or-ed in below
        gpsbb_pkg::OFF_IRQ_STAT: begin
          s_d.rdata[2:0] = s_q.ev_stat;
          s_d.ev_stat = 3'h0; // cleared by the read
        end
        gpsbb_pkg::OFF_IRQ_MASK: s_d.rdata[2:0] = s_q.ev_mask;
        gpsbb_pkg::OFF_IDENT:    s_d.rdata = ident_in;
        default:                 s_d.rdata = 16'h0000;
      endcase
    end

    // pending flags: set wins over a same-cycle clear
    ev_set[gpsbb_pkg::EV_PPS_CHG] = act_chg;
    if (act_chg && s_q.pien) begin
      s_d.pps_change_pending = 1'b1;
    end
    if (rx_done && !fifo_full && s_q.uien && fifo_empty) begin
      s_d.urti = 1'b1; // rises only when data becomes present
    end
    s_d.ev_stat = s_d.ev_stat | ev_set;

    // vectored acknowledge: hand out vector, drop master enable
    if (iack_in && s_q.master_irq_enable && s_q.it && (s_q.pps_change_pending || s_q.urti)) begin
      s_d.vector = icr_byte(s_q);
      s_d.vec_vld = 1'b1;
      s_d.master_irq_enable = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // serial line and its receive sync rest high, so no false start
      s_q <= '{tx_st: gpsbb_pkg::TX_IDLE, rx_st: gpsbb_pkg::RX_IDLE,
               tx_sh: 10'h3FF, rx_sync: 2'h3, ev_mask: gpsbb_pkg::EV_MASK_RESET,
               ident: gpsbb_pkg::IDENT_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; popped byte is taken from the memory register
  assign rdata_out           = s_q.pop_pend ? {8'h00, fifo_rdata} : s_q.rdata;
  assign vector_out          = s_q.vector;
  assign vector_valid_out    = s_q.vec_vld;
  // type A holds the request until cleared; type C drops it through master_irq_enable
  assign irq_out             = (s_q.master_irq_enable && (s_q.pps_change_pending || s_q.urti))
                               || |(s_q.ev_stat & s_q.ev_mask);
  assign tx_out              = s_q.tx_sh[0];
  assign pps_active_flag_out = s_q.act;
  assign pps_lamp_out        = s_q.act;
  assign ident_sel_out       = s_q.ident[1];
  assign ident_wdata_out     = s_q.ident;
endmodule

//--- dv/gpsbb_properties.sv
`timescale 1ns/1ps
// port-level checks of the bridge; one clock domain
module gpsbb_properties (
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  input wire logic [7:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        iospace_in,
  input wire logic        iack_in,
  input wire logic        pps_in,
  input wire logic [15:0] rdata_out,
  input wire logic        vector_valid_out,
  input wire logic        irq_out,
  input wire logic        tx_out,
  input wire logic        pps_active_flag_out,
  input wire logic        pps_lamp_out,
  input wire logic [15:0] ident_wdata_out
);
  logic rd_q;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // taken read one cycle back; read data must be zero otherwise
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_in & iospace_in;
    end
  end
  property p_rd_zero;
    !rd_q |-> rdata_out == 16'h0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
  property p_act_rise;
    $rose(pps_in) |-> ##[2:5] pps_active_flag_out;
  endproperty
  a_act_rise: assert property (p_act_rise) else $error("activity missed a pulse");
  // the pulse goes through a synchroniser, so no same-cycle reaction
  property p_act_sync;
    $rose(pps_active_flag_out) |-> $past(pps_in, 2);
  endproperty
  a_act_sync: assert property (p_act_sync) else $error("activity rose too early");
  property p_lamp;
    pps_lamp_out == pps_active_flag_out;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp differs from activity");
  property p_vec;
    vector_valid_out |-> $past(iack_in);
  endproperty
  a_vec: assert property (p_vec) else $error("vector without acknowledge");
  property p_master_irq_enable;
    vector_valid_out |-> ##[1:2] !irq_out;
  endproperty
  a_master_irq_enable: assert property (p_master_irq_enable) else $error("request held after acknowledge");
  property p_ident;
    (wr_in && iospace_in && addr_in == 8'hFE) |=> ident_wdata_out == $past(wdata_in);
  endproperty
  a_ident: assert property (p_ident) else $error("ident word not taken");
  property p_iomem;
    (wr_in && !iospace_in) |=> $stable(ident_wdata_out);
  endproperty
  a_iomem: assert property (p_iomem) else $error("write outside io space took effect");
  property p_tx_start;
    $fell(tx_out) |-> !tx_out [*8];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit too short");
endmodule
bind gpsbb_top gpsbb_properties u_chk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .iospace_in(iospace_in), .iack_in(iack_in), .pps_in(pps_in), .rdata_out(rdata_out),
  .vector_valid_out(vector_valid_out), .irq_out(irq_out), .tx_out(tx_out),
  .pps_active_flag_out(pps_active_flag_out), .pps_lamp_out(pps_lamp_out),
  .ident_wdata_out(ident_wdata_out));

//--- dv/gpsbb_rcvr_model.sv
`timescale 1ns/1ps
// stand-in for the timing receiver: pulse line and serial port
module gpsbb_rcvr_model (
  input  wire logic sys_clk_in,
  input  wire logic tx_in,
  output logic      pps_out,
  output logic      rx_out
);
  localparam int BC = int'(gpsbb_pkg::BIT_CYC);
  // serial line rests high between frames
  initial begin
    pps_out = 1'b0;
    rx_out = 1'b1;
  end
  // width is arbitrary, the bridge only looks at the edge
  task automatic pulse();
    @(posedge sys_clk_in) pps_out <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    pps_out <= 1'b0;
  endtask
  // 8N1 frame, lsb first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_in) rx_out <= f[i];
      repeat (BC - 1) @(posedge sys_clk_in);
    end
  endtask
  // bounded wait for start bit, then sample mid-bit
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    while (tx_in !== 1'b0 && n < 4000) begin
      @(posedge sys_clk_in);
      n++;
    end
    repeat (BC / 2) @(posedge sys_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge sys_clk_in);
      b[i] = tx_in;
    end
  endtask
endmodule

//--- dv/tb_gpsbb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb_gpsbb_top;
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic        io;
  logic        iack;
  logic        pps;
  logic        rx;
  logic        tx;
  logic [15:0] rdata;
  logic [7:0]  vec;
  logic        vv;
  logic        irq;
  logic        flag;
  logic        lamp;
  logic [15:0] idw;
  logic [7:0]  b;
  logic        i1;
  logic        isel;
  int          errors;
  int          check_count;
  gpsbb_top dut (.sys_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .iospace_in(io), .iack_in(iack), .pps_in(pps),
    .rx_in(rx), .ident_in(16'h1234), .rdata_out(rdata), .vector_out(vec),
    .vector_valid_out(vv), .irq_out(irq), .tx_out(tx), .pps_active_flag_out(flag),
    .pps_lamp_out(lamp), .ident_sel_out(isel), .ident_wdata_out(idw));
  gpsbb_rcvr_model m (.sys_clk_in(clk), .tx_in(tx), .pps_out(pps), .rx_out(rx));
  // 25 MHz
  always #20 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr_s <= 1'b1; end
    @(posedge clk) wr_s <= 1'b0;
  endtask
  // read data is only valid in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) begin addr <= a; rd_s <= 1'b1; end
    @(posedge clk) rd_s <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // limit of about three and a half serial frames; the test itself spends under two
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    clk = 0; nrst = 0; addr = 0; wdata = 0; wr_s = 0; rd_s = 0; io = 1; iack = 0;
    errors = 0; check_count = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rc(8'h00, 16'h0000);
    rc(8'hFE, 16'h1234);
    rc(8'h0A, 16'h0000);
    rc(8'h04, 16'h00FF);
    wr(8'h08, 16'hFFFF);
    rc(8'h08, 16'h0007);
    wr(8'h08, 16'h0000);
    wr(8'hFE, 16'hBEEF);
    @(negedge clk) `CHK(idw, 16'hBEEF)
    `CHK(isel, 1'b1)
    @(posedge clk) io <= 1'b0;
    wr(8'hFE, 16'h0000);
    rc(8'hFE, 16'h0000);
    `CHK(idw, 16'hBEEF)
    @(posedge clk) io <= 1'b1;
    $display("test regs done");
    wr(8'h02, 16'h008A);
    @(negedge clk) `CHK(irq, 1'b0)
    m.pulse();
    repeat (6) @(posedge clk);
    @(negedge clk) `CHK(flag, 1'b1)
    `CHK(lamp, 1'b1)
    rc(8'h00, 16'h0002);
    `CHK(irq, 1'b1)
    rc(8'h02, 16'h00AA);
    rc(8'h06, 16'h0001);
    rc(8'h06, 16'h0000);
    @(posedge clk) iack <= 1'b1;
    @(posedge clk) iack <= 1'b0;
    @(negedge clk) `CHK(vv, 1'b1)
    `CHK(vec, 8'hAA)
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    rc(8'h02, 16'h00A2);
    wr(8'h02, 16'h0020);
    rc(8'h02, 16'h0000);
    $display("test irq done");
    wr(8'h02, 16'h0001);
    m.send(8'h5A);
    repeat (20) @(posedge clk);
    rc(8'h02, 16'h0011);
    wr(8'h02, 16'h0010);
    rc(8'h02, 16'h0000);
    // a set mask bit passes the byte-received status to the request line
    wr(8'h08, 16'h0002);
    @(negedge clk) i1 = irq;
    wr(8'h08, 16'h0000);
    @(negedge clk) `CHK(i1, 1'b1)
    `CHK(irq, 1'b0)
    rc(8'h06, 16'h0002);
    `CHK(irq, 1'b0)
    rc(8'h04, 16'h005A);
    rc(8'h04, 16'h00FF);
    $display("test rx done");
    wr(8'h04, 16'hA53C);
    m.recv(b);
    `CHK(b, 8'h3C)
    $display("test tx done");
    complete_run();
  end
endmodule
